// file: hdl/stm_port.sv
// two-wire slave port, register map and alarm filter of the temperature monitor
`timescale 1ns/10ps
`default_nettype none
module stm_port #(
	parameter logic ALT_VARIANT = 1'b0,
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] SILICON_REV = 8'h03, // arbitrary value
	parameter int unsigned TIMEOUT_CYCLES = stm_pkg::TIMEOUT_CYC
) (
	input wire logic clk, // core clock, 200 MHz
	input wire logic nrst, // async reset, active low
	input wire logic link_clk, // clock of the bus-facing logic
	input wire logic scl_in, // bus clock level seen on the wire
	output logic scl_out, // bus clock drive value, always low
	output logic scl_oe_n, // low while stretching the bus clock
	input wire logic serial_data_line_in, // bus data level seen on the wire
	output logic serial_data_line_out, // bus data drive value, always low
	output logic serial_data_line_oe_n, // low while pulling data low
	output logic alarm_out, // alarm drive value, always low
	output logic alarm_oe_n, // low while the alarm is asserted
	input wire logic [7:0] local_temp_value, // from converter
	input wire logic [7:0] remote_temp_value_high, // from converter
	input wire logic [7:0] remote_temp_value_low, // from converter
	input wire logic [7:0] status_flags, // from comparators
	input wire logic meas_done, // one-cycle pulse per finished measurement
	input wire logic meas_out_of_limit, // level, last measurement out of limit
	output logic single_measure, // one-cycle pulse, start one measurement
	output logic [7:0] configuration, // register
	output logic [7:0] conversion_rate, // register
	output logic [7:0] local_high_limit, // register
	output logic [7:0] local_low_limit, // register
	output logic [7:0] remote_high_limit_high, // register
	output logic [7:0] remote_low_limit_high, // register
	output logic [7:0] remote_offset_high, // register
	output logic [7:0] remote_offset_low, // register
	output logic [7:0] remote_high_limit_low, // register
	output logic [7:0] remote_low_limit_low, // register
	output logic [7:0] remote_failsafe_limit, // register
	output logic [7:0] local_failsafe_limit, // register
	output logic [7:0] failsafe_hysteresis, // register
	output logic [7:0] alarm_filter_and_timeout // register
);
	import stm_pkg::*;

	localparam logic [6:0] DEV_ADDR = ALT_VARIANT ? ADDR_ALT : ADDR_STD;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [1:0] rda_s;
		logic [2:0] abt_s;
		logic [1:0] alm_s;
		stm_lk_e st;
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic sda_drv;
		logic scl_hold;
		logic [1:0] nbytes;
		logic wr_tog;
		logic wr_kind;
		logic [7:0] wr_byte;
		logic rd_req;
		logic ara_tog;
		logic act;
		logic busy;
	} stm_link_s;

	typedef struct packed {
		logic [2:0] wr_s;
		logic [1:0] rd_s;
		logic [2:0] ara_s;
		logic [2:0] act_s;
		logic [1:0] busy_s;
		logic [NSLOT-1:0][7:0] regs;
		logic [7:0] pointer;
		logic [7:0] rd_hold;
		logic rd_ack;
		logic abort;
		logic [TMO_W-1:0] tmo_cnt;
		logic [2:0] fcnt;
		logic alarm;
		logic one_shot;
	} stm_core_s;

	localparam stm_core_s CORE_RST = '{regs: SLOT_RESET, default: '0};

	stm_link_s l;
	stm_link_s next_l;
	stm_core_s c;
	stm_core_s next_c;

	// pointer value to storage slot; bit 4 marks a mapped register
	function automatic logic [4:0] slot_of(input logic [7:0] a, input logic wr);
		logic [7:0] first;
		logic [7:0] last;
		logic [7:0] d;
		first = wr ? WR_CFG_FIRST : RD_CFG_FIRST;
		last = wr ? WR_CFG_LAST : RD_CFG_LAST;
		d = a - first;
		slot_of = 5'h00;
		if (a >= first && a <= last) begin
			slot_of = {1'b1, d[3:0]};
		end else begin
			unique case (a)
				OFS_HIGH: slot_of = {1'b1, SL_OFSH};
				OFS_LOW: slot_of = {1'b1, SL_OFSL};
				RHL_LOW: slot_of = {1'b1, SL_RHLL};
				RLL_LOW: slot_of = {1'b1, SL_RLLL};
				REMOTE_FS: slot_of = {1'b1, SL_RFS};
				LOCAL_FS: slot_of = {1'b1, SL_LFS};
				FS_HYST: slot_of = {1'b1, SL_HYST};
				ALARM_FILTER: slot_of = {1'b1, SL_FILT};
				default: slot_of = 5'h00;
			endcase
		end
	endfunction

	// ---- link domain: bus engine on link_clk ----
	logic scl_r;
	logic scl_f;
	logic bus_start;
	logic bus_stop;
	logic abort_ev;

	// pins pass two flops; stage 3 only feeds edge detection
	assign scl_r = l.scl_s[1] & ~l.scl_s[2];
	assign scl_f = ~l.scl_s[1] & l.scl_s[2];
	assign bus_start = l.scl_s[1] & l.scl_s[2] & l.sda_s[2] & ~l.sda_s[1];
	assign bus_stop = l.scl_s[1] & l.scl_s[2] & ~l.sda_s[2] & l.sda_s[1];
	assign abort_ev = l.abt_s[1] ^ l.abt_s[2];

	// bus engine next state
	always_comb begin
		next_l = l;
		next_l.scl_s = {l.scl_s[1:0], scl_in};
		next_l.sda_s = {l.sda_s[1:0], serial_data_line_in};
		next_l.rda_s = {l.rda_s[0], c.rd_ack};
		next_l.abt_s = {l.abt_s[1:0], c.abort};
		next_l.alm_s = {l.alm_s[0], c.alarm};
		if (scl_r | scl_f) begin
			next_l.act = ~l.act;
		end
		if (abort_ev) begin
			next_l.st = LK_IDLE;
			next_l.sda_drv = 1'b0;
			next_l.scl_hold = 1'b0;
		end else if (bus_start) begin
			// a repeated start also lands here, so direction is chosen afresh
			next_l.st = LK_ADDR;
			next_l.bitcnt = 4'h0;
			next_l.sda_drv = 1'b0;
			next_l.scl_hold = 1'b0;
		end else if (bus_stop) begin
			next_l.st = LK_IDLE;
			next_l.sda_drv = 1'b0;
			next_l.scl_hold = 1'b0;
		end else begin
			unique case (l.st)
				LK_IDLE, LK_IGNORE: begin
				end
				LK_ADDR: begin
					if (scl_r) begin
						next_l.sh = {l.sh[6:0], l.sda_s[1]};
						next_l.bitcnt = l.bitcnt + 4'h1;
					end else if (scl_f && l.bitcnt == 4'h8) begin
						if (l.sh[7:1] == DEV_ADDR && !l.sh[0]) begin
							next_l.sda_drv = 1'b1;
							next_l.nbytes = 2'h0;
							next_l.st = LK_WACK;
						end else if (l.sh[7:1] == DEV_ADDR) begin
							// stretch the clock until the core hands over the byte
							next_l.sda_drv = 1'b1;
							next_l.scl_hold = 1'b1;
							next_l.rd_req = ~l.rd_req;
							next_l.st = LK_RWAIT;
						end else if (l.sh[7:1] == ALARM_RESP_ADDR && l.sh[0] && l.alm_s[1]) begin
							next_l.sda_drv = 1'b1;
							next_l.sh = {DEV_ADDR, 1'b1};
							next_l.ara_tog = ~l.ara_tog;
							next_l.st = LK_RACK;
						end else begin
							next_l.st = LK_IGNORE;
						end
					end
				end
				LK_WACK: begin
					if (scl_f) begin
						next_l.sda_drv = 1'b0;
						next_l.bitcnt = 4'h0;
						next_l.st = LK_WDATA;
					end
				end
				LK_WDATA: begin
					if (scl_r) begin
						next_l.sh = {l.sh[6:0], l.sda_s[1]};
						next_l.bitcnt = l.bitcnt + 4'h1;
					end else if (scl_f && l.bitcnt == 4'h8) begin
						if (l.nbytes == 2'h2) begin
							next_l.st = LK_IGNORE;
						end else begin
							// byte stays held here until the next one; the core
							// picks it up well before that
							next_l.wr_kind = (l.nbytes != 2'h0);
							next_l.wr_byte = l.sh;
							next_l.wr_tog = ~l.wr_tog;
							next_l.nbytes = l.nbytes + 2'h1;
							next_l.sda_drv = 1'b1;
							next_l.st = LK_WACK;
						end
					end
				end
				LK_RWAIT: begin
					if (l.rda_s[1] == l.rd_req) begin
						next_l.sh = c.rd_hold;
						next_l.scl_hold = 1'b0;
						next_l.st = LK_RACK;
					end
				end
				LK_RACK: begin
					if (scl_f) begin
						next_l.sda_drv = ~l.sh[7];
						next_l.bitcnt = 4'h0;
						next_l.st = LK_RDATA;
					end
				end
				LK_RDATA: begin
					if (scl_r) begin
						next_l.bitcnt = l.bitcnt + 4'h1;
					end else if (scl_f && l.bitcnt == 4'h8) begin
						// one byte only; release for the master's nack and stop
						next_l.sda_drv = 1'b0;
						next_l.st = LK_IGNORE;
					end else if (scl_f) begin
						next_l.sh = {l.sh[6:0], 1'b0};
						next_l.sda_drv = ~l.sh[6];
					end
				end
			endcase
		end
		next_l.busy = (next_l.st != LK_IDLE);
	end

	// bus engine registers; pins idle released
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			l <= '{st: LK_IDLE, scl_s: 3'h7, sda_s: 3'h7, default: '0};
		end else begin
			l <= next_l;
		end
	end

	assign scl_out = 1'b0;
	assign scl_oe_n = ~l.scl_hold;
	assign serial_data_line_out = 1'b0;
	assign serial_data_line_oe_n = ~l.sda_drv;

	// ---- core domain: registers, filter, timeout on clk ----
	logic wr_ev;
	logic ara_ev;
	logic act_ev;
	logic [4:0] wr_slot;
	logic [4:0] rd_slot;
	logic [2:0] need;
	logic [2:0] fcnt_inc;

	assign wr_ev = c.wr_s[1] ^ c.wr_s[2];
	assign ara_ev = c.ara_s[1] ^ c.ara_s[2];
	assign act_ev = c.act_s[1] ^ c.act_s[2];
	assign wr_slot = slot_of(c.pointer, 1'b1);
	assign rd_slot = slot_of(c.pointer, 1'b0);
	// thermometer code in bits 3:1; stray patterns fall to the highest set bit
	assign need = c.regs[SL_FILT][3] ? 3'h4 : c.regs[SL_FILT][2] ? 3'h3 :
		c.regs[SL_FILT][1] ? 3'h2 : 3'h1;
	assign fcnt_inc = (c.fcnt == FILT_MAX) ? FILT_MAX : c.fcnt + 3'h1;

	// core next state
	always_comb begin
		next_c = c;
		next_c.wr_s = {c.wr_s[1:0], l.wr_tog};
		next_c.rd_s = {c.rd_s[0], l.rd_req};
		next_c.ara_s = {c.ara_s[1:0], l.ara_tog};
		next_c.act_s = {c.act_s[1:0], l.act};
		next_c.busy_s = {c.busy_s[0], l.busy};
		next_c.one_shot = 1'b0;
		if (wr_ev) begin
			if (!l.wr_kind) begin
				next_c.pointer = l.wr_byte;
			end else if (c.pointer == WR_ONE_SHOT) begin
				next_c.one_shot = 1'b1;
			end else if (wr_slot[4]) begin
				next_c.regs[wr_slot[3:0]] = l.wr_byte;
			end
		end
		// read handover: byte captured in the cycle the ack toggles, stable long before the link sees it
		if (c.rd_s[1] != c.rd_ack) begin
			next_c.rd_ack = c.rd_s[1];
			if (rd_slot[4]) begin
				next_c.rd_hold = c.regs[rd_slot[3:0]];
			end else begin
				unique case (c.pointer)
					RD_LOCAL_TEMP: next_c.rd_hold = local_temp_value;
					RD_REMOTE_HIGH: next_c.rd_hold = remote_temp_value_high;
					RD_STATUS: next_c.rd_hold = status_flags;
					RD_REMOTE_LOW: next_c.rd_hold = remote_temp_value_low;
					RD_MAKER: next_c.rd_hold = MAKER_CODE;
					RD_REVISION: next_c.rd_hold = SILICON_REV;
					default: next_c.rd_hold = 8'h00;
				endcase
			end
		end
		// alarm latch: clear first so a same-cycle set wins
		if (ara_ev && !meas_out_of_limit) begin
			next_c.alarm = 1'b0;
		end
		if (meas_done) begin
			if (meas_out_of_limit) begin
				next_c.fcnt = fcnt_inc;
				if (fcnt_inc >= need) begin
					next_c.alarm = 1'b1;
				end
			end else begin
				next_c.fcnt = 3'h0;
			end
		end
		// inactivity timer; only runs while a transfer is open
		if (!c.busy_s[1] || act_ev || !c.regs[SL_FILT][FILT_TMO_BIT]) begin
			next_c.tmo_cnt = '0;
		end else if (c.tmo_cnt == TMO_W'(TIMEOUT_CYCLES - 1)) begin
			next_c.abort = ~c.abort;
			next_c.tmo_cnt = '0;
		end else begin
			next_c.tmo_cnt = c.tmo_cnt + TMO_W'(1);
		end
	end

	// core registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			c <= CORE_RST;
		end else begin
			c <= next_c;
		end
	end

	assign alarm_out = 1'b0;
	assign alarm_oe_n = ~c.alarm;
	assign single_measure = c.one_shot;
	assign configuration = c.regs[SL_CFG];
	assign conversion_rate = c.regs[SL_RATE];
	assign local_high_limit = c.regs[SL_LHL];
	assign local_low_limit = c.regs[SL_LLL];
	assign remote_high_limit_high = c.regs[SL_RHLH];
	assign remote_low_limit_high = c.regs[SL_RLLH];
	assign remote_offset_high = c.regs[SL_OFSH];
	assign remote_offset_low = c.regs[SL_OFSL];
	assign remote_high_limit_low = c.regs[SL_RHLL];
	assign remote_low_limit_low = c.regs[SL_RLLL];
	assign remote_failsafe_limit = c.regs[SL_RFS];
	assign local_failsafe_limit = c.regs[SL_LFS];
	assign failsafe_hysteresis = c.regs[SL_HYST];
	assign alarm_filter_and_timeout = c.regs[SL_FILT];

	// ---- checks ----
	sequence addr_done_s;
		l.st == LK_ADDR && scl_f && l.bitcnt == 4'h8 && !abort_ev && !bus_start && !bus_stop;
	endsequence
	sequence data_wr_s;
		wr_ev && l.wr_kind;
	endsequence

	filter_reset_a: assert property (@(posedge clk) $rose(nrst) |-> c.regs[SL_FILT] == 8'h01)
		else $error("filter register not 0x01 after reset");
	alarm_cause_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(c.alarm) |-> $past(meas_done && meas_out_of_limit && fcnt_inc >= need))
		else $error("alarm rose without enough failures");
	alarm_single_a: assert property (@(posedge clk) disable iff (!nrst)
		meas_done && meas_out_of_limit && need == 3'h1 |=> c.alarm)
		else $error("single failure did not raise alarm");
	timeout_off_a: assert property (@(posedge clk) disable iff (!nrst)
		!c.regs[SL_FILT][FILT_TMO_BIT] ##1 !c.regs[SL_FILT][FILT_TMO_BIT] |-> $stable(c.abort))
		else $error("timeout fired while disabled");
	one_shot_a: assert property (@(posedge clk) disable iff (!nrst)
		data_wr_s and (c.pointer == WR_ONE_SHOT) |=> single_measure ##1 !single_measure)
		else $error("one-shot write gave no single pulse");
	ptr_load_a: assert property (@(posedge clk) disable iff (!nrst)
		wr_ev && !l.wr_kind |=> c.pointer == $past(l.wr_byte))
		else $error("first write byte not loaded into pointer");
	alias_store_a: assert property (@(posedge clk) disable iff (!nrst)
		data_wr_s and (c.pointer == WR_CFG_FIRST) |=> configuration == $past(l.wr_byte))
		else $error("configuration alias write not stored");
	addr_ack_a: assert property (@(posedge link_clk) disable iff (!nrst)
		addr_done_s and (l.sh[7:1] == DEV_ADDR) |=> l.sda_drv [*2])
		else $error("own address not acknowledged");
	foreign_addr_a: assert property (@(posedge link_clk) disable iff (!nrst)
		addr_done_s and (l.sh[7:1] != DEV_ADDR && l.sh[7:1] != ALARM_RESP_ADDR)
		|=> !l.sda_drv && l.st == LK_IGNORE)
		else $error("foreign address answered");
	third_byte_a: assert property (@(posedge link_clk) disable iff (!nrst)
		l.st == LK_WDATA && scl_f && l.bitcnt == 4'h8 && l.nbytes == 2'h2 && !bus_start
		&& !bus_stop && !abort_ev |=> !l.sda_drv && l.st == LK_IGNORE)
		else $error("third write byte acknowledged");
	ara_reply_a: assert property (@(posedge link_clk) disable iff (!nrst)
		addr_done_s and (l.sh == {ALARM_RESP_ADDR, 1'b1}) and l.alm_s[1]
		|=> l.sh == {DEV_ADDR, 1'b1} && l.st == LK_RACK)
		else $error("alarm response did not load own address");
	idle_free_a: assert property (@(posedge link_clk) disable iff (!nrst)
		l.st == LK_IDLE |-> !l.sda_drv && !l.scl_hold)
		else $error("bus driven while idle");
endmodule
`default_nettype wire

// file: hdl/stm_pkg.sv
// shared constants and types of the temperature monitor bus port
package stm_pkg;
	// seven-bit bus addresses
	localparam logic [6:0] ADDR_STD = 7'h4c;
	localparam logic [6:0] ADDR_ALT = 7'h4d;
	localparam logic [6:0] ALARM_RESP_ADDR = 7'h0c;
	// pointer values
	localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
	localparam logic [7:0] RD_REMOTE_HIGH = 8'h01;
	localparam logic [7:0] RD_STATUS = 8'h02;
	localparam logic [7:0] RD_CFG_FIRST = 8'h03;
	localparam logic [7:0] RD_CFG_LAST = 8'h08;
	localparam logic [7:0] WR_CFG_FIRST = 8'h09;
	localparam logic [7:0] WR_CFG_LAST = 8'h0e;
	localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
	localparam logic [7:0] RD_REMOTE_LOW = 8'h10;
	localparam logic [7:0] OFS_HIGH = 8'h11;
	localparam logic [7:0] OFS_LOW = 8'h12;
	localparam logic [7:0] RHL_LOW = 8'h13;
	localparam logic [7:0] RLL_LOW = 8'h14;
	localparam logic [7:0] REMOTE_FS = 8'h19;
	localparam logic [7:0] LOCAL_FS = 8'h20;
	localparam logic [7:0] FS_HYST = 8'h21;
	localparam logic [7:0] ALARM_FILTER = 8'h22;
	localparam logic [7:0] RD_MAKER = 8'hfe;
	localparam logic [7:0] RD_REVISION = 8'hff;
	// storage slots of the writable registers
	localparam int NSLOT = 14;
	localparam logic [3:0] SL_CFG = 4'h0;
	localparam logic [3:0] SL_RATE = 4'h1;
	localparam logic [3:0] SL_LHL = 4'h2;
	localparam logic [3:0] SL_LLL = 4'h3;
	localparam logic [3:0] SL_RHLH = 4'h4;
	localparam logic [3:0] SL_RLLH = 4'h5;
	localparam logic [3:0] SL_OFSH = 4'h6;
	localparam logic [3:0] SL_OFSL = 4'h7;
	localparam logic [3:0] SL_RHLL = 4'h8;
	localparam logic [3:0] SL_RLLL = 4'h9;
	localparam logic [3:0] SL_RFS = 4'ha;
	localparam logic [3:0] SL_LFS = 4'hb;
	localparam logic [3:0] SL_HYST = 4'hc;
	localparam logic [3:0] SL_FILT = 4'hd;
	// values after reset, slot 13 leftmost
	localparam logic [NSLOT-1:0][7:0] SLOT_RESET = {8'h01, 8'h0a, 8'h55, 8'h55,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h55, 8'h08, 8'h00};
	// filter register fields
	localparam int FILT_TMO_BIT = 7;
	localparam logic [2:0] FILT_MAX = 3'h4;
	// bus inactivity timeout
	localparam int TIMEOUT_MS = 25;
	localparam int CLK_KHZ = 200000;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
	localparam int TMO_W = 23;
	// link engine states
	typedef enum logic [2:0] {
		LK_IDLE = 3'b000, LK_ADDR = 3'b001, LK_WACK = 3'b010, LK_WDATA = 3'b011,
		LK_RWAIT = 3'b100, LK_RACK = 3'b101, LK_RDATA = 3'b110, LK_IGNORE = 3'b111
	} stm_lk_e;
endpackage

// file: verif/stm_host_model.sv
// bit-level two-wire bus master acting as the far side of the port
`timescale 1ns/10ps
`default_nettype none
module stm_host_model #(
	parameter int HALF = 100
) (
	input wire logic clk, // bench clock
	input wire logic scl_w, // resolved bus clock
	input wire logic sda_w, // resolved bus data
	output logic scl_rel, // high releases the bus clock
	output logic sda_rel // high releases the bus data
);
	// both lines released, so the pull-ups hold the bus idle
	initial begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
	end
	// half a bus period in bench clocks
	task automatic half();
		repeat (HALF) @(posedge clk);
	endtask
	// release the clock; the port may stretch it, so the wait is bounded
	task automatic rise();
		scl_rel <= 1'b1;
		for (int i = 0; i < 4000 && scl_w !== 1'b1; i++) @(posedge clk);
		half();
	endtask
	// one bit; data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		sda_rel <= b;
		half();
		rise();
		s = sda_w;
		scl_rel <= 1'b0;
		@(posedge clk);
	endtask
	// start or repeated start: data falls while the clock is high
	task automatic start();
		sda_rel <= 1'b1;
		half();
		rise();
		sda_rel <= 1'b0;
		half();
		scl_rel <= 1'b0;
		@(posedge clk);
	endtask
	// stop, then a quiet gap before the next transfer
	task automatic stop();
		sda_rel <= 1'b0;
		half();
		rise();
		sda_rel <= 1'b1;
		half();
		half();
	endtask
	// eight bits msb first, then the acknowledge slot
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	// one byte in, answered with a no-acknowledge to end the read
	task automatic recv(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(1'b1, s);
	endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the temperature monitor bus port
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import stm_pkg::*;
	localparam int TMO = 1000;
	localparam logic [7:0] RA [14] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11,
		8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h22};
	localparam logic [7:0] RST [14] = '{8'h00, 8'h08, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0a, 8'h01};
	localparam logic [2:0] CODES [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
	logic clk, link_clk, nrst, meas_done, meas_out_of_limit;
	logic scl_rel, sda_rel, scl_oe_n, sda_oe_n, alarm_oe_n, single_measure;
	logic [7:0] lt, rth, rtl, st, ptr;
	logic [7:0] mem [256];
	logic [31:0] rs = 32'h24;
	wire logic scl_w, sda_w, scl_o, sda_o, alm_o;
	wire logic [13:0][7:0] pv;
	int fail_count, samples_checked;
	int sm_cnt = 0;
	// open-drain lines with pull-ups; a released driver leaves the pull-up in charge
	assign scl_w = scl_rel & (scl_oe_n | scl_o);
	assign sda_w = sda_rel & (sda_oe_n | sda_o);
	stm_port #(.TIMEOUT_CYCLES(TMO)) i_dut (.clk(clk), .nrst(nrst), .link_clk(link_clk),
		.scl_in(scl_w), .scl_out(scl_o), .scl_oe_n(scl_oe_n), .serial_data_line_in(sda_w),
		.serial_data_line_out(sda_o), .serial_data_line_oe_n(sda_oe_n), .alarm_out(alm_o),
		.alarm_oe_n(alarm_oe_n), .local_temp_value(lt), .remote_temp_value_high(rth),
		.remote_temp_value_low(rtl), .status_flags(st), .meas_done(meas_done),
		.meas_out_of_limit(meas_out_of_limit), .single_measure(single_measure),
		.configuration(pv[0]), .conversion_rate(pv[1]), .local_high_limit(pv[2]),
		.local_low_limit(pv[3]), .remote_high_limit_high(pv[4]),
		.remote_low_limit_high(pv[5]), .remote_offset_high(pv[6]),
		.remote_offset_low(pv[7]), .remote_high_limit_low(pv[8]),
		.remote_low_limit_low(pv[9]), .remote_failsafe_limit(pv[10]),
		.local_failsafe_limit(pv[11]), .failsafe_hysteresis(pv[12]),
		.alarm_filter_and_timeout(pv[13]));
	stm_host_model #(.HALF(100)) i_host (.clk(clk), .scl_w(scl_w), .sda_w(sda_w),
		.scl_rel(scl_rel), .sda_rel(sda_rel));
	// core clock and a link clock of unrelated phase
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	// count measurement start pulses
	always @(posedge clk) begin
		if (single_measure === 1'b1) sm_cnt++;
	end
	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction
	// write alias to storage address, -1 when nothing is stored
	function automatic int wmap(logic [7:0] p);
		if (p >= 8'h09 && p <= 8'h0e) return p - 6;
		foreach (RA[i]) if (RA[i] == p && p > 8'h10) return p;
		return -1;
	endfunction
	function automatic logic [7:0] mdl_rd(logic [7:0] p);
		case (p)
			8'h00: return lt;
			8'h01: return rth;
			8'h02: return st;
			8'h10: return rtl;
			default: return mem[p];
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk_regs();
		for (int i = 0; i < 14; i++) chk(pv[i], mem[RA[i]]);
	endtask
	// pointer byte, then n data bytes; only the first data byte counts
	task automatic bus_wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d0,
		input int n, output int acks);
		logic k;
		logic [7:0] d;
		acks = 0;
		i_host.start();
		i_host.send({a, 1'b0}, k);
		acks += k;
		if (k) begin
			i_host.send(p, k);
			acks += k;
			ptr = p;
			for (int j = 0; j < n; j++) begin
				d = (j == 0) ? d0 : rnd();
				i_host.send(d, k);
				acks += k;
				if (j == 0 && wmap(p) >= 0) mem[wmap(p)] = d;
			end
		end
		i_host.stop();
	endtask
	task automatic bus_rd(input logic [6:0] a, output logic [7:0] d, output logic k);
		d = 8'h00;
		i_host.start();
		i_host.send({a, 1'b1}, k);
		if (k) i_host.recv(d);
		i_host.stop();
	endtask
	task automatic meas(input logic o);
		meas_out_of_limit <= o;
		meas_done <= 1'b1;
		@(posedge clk);
		meas_done <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// watchdog, only slightly above the length of the sequence
	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		finish_test();
	end
	initial begin
		logic [7:0] d, r;
		logic k;
		int n, m, i;
		nrst = 1'b0;
		meas_done = 1'b0;
		meas_out_of_limit = 1'b0;
		{lt, rth, rtl, st, ptr} = '0;
		fail_count = 0;
		samples_checked = 0;
		foreach (mem[j]) mem[j] = 8'h00;
		foreach (RA[j]) mem[RA[j]] = RST[j];
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (40) @(posedge clk);
		chk_regs();
		chk({alarm_oe_n, sda_oe_n, scl_oe_n, single_measure, alm_o}, 5'b11100);
		// read through a pointer, then again with the pointer left alone
		{lt, rth, rtl, st} <= {rnd(), rnd(), rnd(), rnd()};
		bus_wr(ADDR_STD, RD_LOCAL_TEMP, 8'h00, 0, n);
		chk(n, 2);
		bus_rd(ADDR_STD, d, k);
		chk({k, d}, {1'b1, mdl_rd(ptr)});
		lt <= rnd();
		bus_rd(ADDR_STD, d, k);
		chk(d, mdl_rd(ptr));
		// write aliases at both ends, a refused third byte, readback at the read address
		bus_wr(ADDR_STD, WR_CFG_FIRST, rnd(), 2, n);
		chk(n, 3);
		chk_regs();
		bus_wr(ADDR_STD, WR_CFG_LAST, rnd(), 1, n);
		chk_regs();
		bus_wr(ADDR_STD, RD_CFG_LAST, 8'h00, 0, n);
		bus_rd(ADDR_STD, d, k);
		chk(d, mem[8'h08]);
		// measurement trigger stores nothing
		m = sm_cnt;
		bus_wr(ADDR_STD, WR_ONE_SHOT, rnd(), 1, n);
		chk(sm_cnt - m, 1);
		chk_regs();
		// foreign address and an alarm response with no alarm pending
		bus_wr(ADDR_ALT, ALARM_FILTER, 8'hff, 1, n);
		chk(n, 0);
		bus_rd(ADDR_ALT, d, k);
		chk(k, 0);
		bus_rd(ALARM_RESP_ADDR, d, k);
		chk(k, 0);
		chk_regs();
		// each filter code: an in-limit result restarts the count; the last enables timeout
		for (int c = 0; c < 4; c++) begin
			r = rnd();
			bus_wr(ADDR_STD, ALARM_FILTER, {c == 3, r[6:4], CODES[c], r[0]}, 1, n);
			chk_regs();
			// failures left from the last round would still count, so restart the filter
			meas(1'b0);
			repeat (c) meas(1'b1);
			meas(1'b0);
			repeat (c) meas(1'b1);
			chk(alarm_oe_n, 1);
			meas(1'b1);
			chk(alarm_oe_n, 0);
			meas_out_of_limit <= 1'b0;
			bus_rd(ALARM_RESP_ADDR, d, k);
			chk({k, d}, {1'b1, ADDR_STD, 1'b1});
			for (i = 0; i < 200 && alarm_oe_n !== 1'b1; i++) @(posedge clk);
			chk(alarm_oe_n, 1);
		end
		// address byte sent, clock then held low: the acknowledge must be dropped
		i_host.start();
		d = {ADDR_STD, 1'b0};
		for (int j = 7; j >= 0; j--) i_host.bit_io(d[j], k);
		for (i = 0; i < 100 && sda_oe_n !== 1'b0; i++) @(posedge clk);
		chk(sda_oe_n, 0);
		for (i = 0; i < TMO + 1000 && sda_oe_n !== 1'b1; i++) @(posedge clk);
		chk(sda_oe_n, 1);
		chk(i >= TMO - 300, 1);
		i_host.stop();
		finish_test();
	end
endmodule
`default_nettype wire
